// ===== pir_rom_window.sv
`timescale 1ns/1ns
// How it works
// RULE_01: Message-unit enable moves memory base to 18h
// RULE_02: Software orders block, class, enable, unblock steps
// RULE_03: Access block bit retries every host access
// RULE_04: Class code loads from EEPROM or processor
// RULE_05: Host sets memory space before ROM reads
// RULE_06: ROM base bits 31:16, enable gates hits
// RULE_07: ROM width, block, translation read-only, EEPROM-loaded
// RULE_08: Transfer code lines driven during ROM access
// RULE_09: EEPROM control and product data writes
// RULE_10: ROM hit forwards with translated upper address
module pir_rom_window
  import pir_pkg::*;
#(
  parameter int PD_DEPTH = 16,
  parameter int PD_AW = 4
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host configuration port
  input wire logic h_cfg_req,
  input wire pir_reg_req_t h_cfg,
  output logic h_cfg_ack,
  output logic h_cfg_retry,
  output logic [31:0] h_cfg_rdata,
  // Host memory port
  input wire logic h_mem_req,
  input wire logic [31:0] h_mem_addr,
  output logic h_mem_ack,
  output logic h_mem_retry,
  // Local forwarded ROM access
  output logic l_fwd_valid,
  output logic [31:0] l_fwd_addr,
  output logic [3:0] transfer_code_lines,
  input wire logic l_fwd_ready,
  // Local processor register port
  input wire logic l_req,
  input wire pir_reg_req_t l_reg,
  output logic l_ack,
  output logic [31:0] l_rdata,
  // EEPROM load stream
  input wire logic ee_ld_valid,
  input wire logic [1:0] ee_ld_sel,
  input wire logic [31:0] ee_ld_data,
  // EEPROM write request
  output logic ee_wr_valid,
  output pir_ee_write_t ee_wr,
  input wire logic ee_wr_done
);
  // ****************************************
  // State
  // ****************************************
  logic [31:0] class_reg;          // Class code
  logic access_block_reg;          // Withholds host access
  logic msg_enable_reg;            // Message unit enable
  logic mem_space_reg;             // Host memory space enable
  logic [31:0] membase_reg;        // Memory base register
  logic [15:0] rom_base_reg;       // ROM base upper bits
  logic rom_en_reg;                // ROM image enable
  pir_rom_ctrl_t rom_ctrl_reg;     // Read-only window control
  logic [31:0] fwd_addr_reg;       // Held forward address
  logic fwd_busy_reg;              // Forward outstanding
  logic [31:0] h_rdata_reg;        // Host read data
  logic [31:0] l_rdata_reg;        // Local read data
  logic pd_read_reg;               // Host read of product data pending
  logic [PD_AW-1:0] pd_rd_addr_reg;  // Product data read index
  logic [PD_AW-1:0] pd_rd_addr_next; // Next read index
  logic [PD_AW-1:0] pd_rd_sel;     // Index presented to the memory
  logic [7:0] pd_rd_data;          // Memory read data
  logic pd_wr_en;                  // Product data write strobe

  // Memory base offset, steered by message unit enable
  function automatic logic [7:0] membase_offset(input logic moved);
    membase_offset = moved ? HCFG_MEMBASE_MOVED : HCFG_MEMBASE_NORMAL;
  endfunction : membase_offset

  // ****************************************
  // Host access decode
  // ****************************************
  logic h_take;
  logic ee_take_host;
  logic ee_take_local;
  logic rom_hit;

  // Retried while blocked or, for writes to EEPROM, while busy
  assign h_cfg_retry = h_cfg_req & (access_block_reg | // RULE_03
                       (h_cfg.wr & h_cfg.addr == HCFG_PRODUCT_DATA & ee_wr_valid));
  assign h_take = h_cfg_req & ~h_cfg_retry;
  assign h_cfg_ack = h_take;
  assign h_cfg_rdata = pd_read_reg ? {16'h0000, pd_rd_data, 8'h00} : h_rdata_reg;
  assign ee_take_host = h_take & h_cfg.wr & (h_cfg.addr == HCFG_PRODUCT_DATA); // RULE_09
  assign ee_take_local = l_req & l_reg.wr & (l_reg.addr == LREG_EE_CTRL) & ~ee_wr_valid & ~ee_take_host;
  assign pd_wr_en = ee_take_host;
  assign pd_rd_addr_next = h_cfg.wdata[PD_AW+7:8];
  // New index goes straight in, so the byte stands in the cycle after ack
  assign pd_rd_sel = (h_take & ~h_cfg.wr & (h_cfg.addr == HCFG_PRODUCT_DATA)) ? pd_rd_addr_next : pd_rd_addr_reg;

  // Window hit needs memory space, enable and base match
  assign rom_hit = mem_space_reg & rom_en_reg & (h_mem_addr[31:16] == rom_base_reg); // RULE_06
  assign h_mem_retry = h_mem_req & (access_block_reg | fwd_busy_reg | ~rom_hit); // RULE_03
  assign h_mem_ack = l_fwd_valid & l_fwd_ready;
  assign l_fwd_valid = fwd_busy_reg;
  assign l_fwd_addr = fwd_addr_reg;
  // Lines carry the code only while the access is out
  assign transfer_code_lines = fwd_busy_reg ? rom_ctrl_reg.transfer_code : 4'h0; // RULE_08
  assign l_ack = l_req & ~(l_reg.wr & l_reg.addr == LREG_EE_CTRL & (ee_wr_valid | ee_take_host));
  assign l_rdata = l_rdata_reg;

  // ****************************************
  // Product data shadow
  // ****************************************
  pir_product_mem #(.DEPTH(PD_DEPTH), .AW(PD_AW)) u_pd_mem (
    .clk(clk),
    .rst(rst),
    .wr_en(pd_wr_en),
    .wr_addr(h_cfg.wdata[PD_AW-1:0]),
    .wr_data(h_cfg.wdata[15:8]),
    .rd_addr(pd_rd_sel),
    .rd_data(pd_rd_data)
  );

  // ****************************************
  // Local processor writes and EEPROM loads
  // ****************************************
  // Local write wins over a same-cycle EEPROM load
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      class_reg <= CLASS_RESET;
      access_block_reg <= ACCESS_BLOCK_RESET;
      msg_enable_reg <= 1'b0;
      rom_ctrl_reg <= ROM_CTRL_RESET;
    end
    else
    begin
      if (ee_ld_valid && ee_ld_sel == LOAD_CLASS)
      begin
        class_reg <= ee_ld_data; // RULE_04
      end
      if (ee_ld_valid && ee_ld_sel == LOAD_ROM_CTRL)
      begin
        rom_ctrl_reg <= ee_ld_data; // RULE_07
      end
      if (l_req && l_reg.wr)
      begin
        unique case (l_reg.addr)
          LREG_MISC_TWO: access_block_reg <= l_reg.wdata[ACCESS_BLOCK_BIT]; // RULE_02
          LREG_MSG_CTRL: msg_enable_reg <= l_reg.wdata[MSG_EN_BIT];
          LREG_CLASS: class_reg <= l_reg.wdata; // RULE_04
          default: ;
        endcase
      end
    end
  end

  // Local read data; window control is read-only here too
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      l_rdata_reg <= 32'h0000_0000;
    end
    else if (l_req && !l_reg.wr)
    begin
      unique case (l_reg.addr)
        LREG_MISC_TWO: l_rdata_reg <= {31'h0, access_block_reg};
        LREG_MSG_CTRL: l_rdata_reg <= {31'h0, msg_enable_reg};
        LREG_CLASS: l_rdata_reg <= class_reg;
        LREG_EE_CTRL: l_rdata_reg <= {ee_wr_valid, 15'h0, ee_wr};
        LREG_ROM_CTRL: l_rdata_reg <= rom_ctrl_reg;
        default: l_rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Host configuration registers
  // ****************************************
  // Class and window control are not host-writable
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mem_space_reg <= 1'b0;
      membase_reg <= 32'h0000_0000;
      rom_base_reg <= 16'h0000;
      rom_en_reg <= 1'b0;
    end
    else
    begin
      if (ee_ld_valid && ee_ld_sel == LOAD_ROM_BASE)
      begin
        rom_base_reg <= ee_ld_data[31:16];
        rom_en_reg <= ee_ld_data[ROM_EN_BIT];
      end
      if (h_take && h_cfg.wr)
      begin
        if (h_cfg.addr == HCFG_CMD_STATUS)
        begin
          mem_space_reg <= h_cfg.wdata[MEM_SPACE_BIT]; // RULE_05
        end
        if (h_cfg.addr == membase_offset(msg_enable_reg))
        begin
          membase_reg <= h_cfg.wdata & MEMBASE_MASK; // RULE_01
        end
        if (h_cfg.addr == HCFG_ROM_BASE)
        begin
          rom_base_reg <= h_cfg.wdata[31:16]; // RULE_06
          rom_en_reg <= h_cfg.wdata[ROM_EN_BIT];
        end
      end
    end
  end

  // Host read data
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      h_rdata_reg <= 32'h0000_0000;
      pd_read_reg <= 1'b0;
      pd_rd_addr_reg <= '0;
    end
    else
    begin
      pd_read_reg <= h_take && !h_cfg.wr && h_cfg.addr == HCFG_PRODUCT_DATA;
      if (h_take && !h_cfg.wr)
      begin
        if (h_cfg.addr == HCFG_CMD_STATUS)
        begin
          h_rdata_reg <= {30'h0, mem_space_reg, 1'b0};
        end
        else if (h_cfg.addr == HCFG_CLASS)
        begin
          h_rdata_reg <= class_reg;
        end
        else if (h_cfg.addr == membase_offset(msg_enable_reg))
        begin
          h_rdata_reg <= membase_reg; // RULE_01
        end
        else if (h_cfg.addr == HCFG_ROM_BASE)
        begin
          h_rdata_reg <= {rom_base_reg, 15'h0, rom_en_reg};
        end
        else
        begin
          h_rdata_reg <= 32'h0000_0000;
        end
      end
      if (h_take && h_cfg.wr && h_cfg.addr == HCFG_PRODUCT_DATA)
      begin
        pd_rd_addr_reg <= h_cfg.wdata[PD_AW-1:0];
      end
      else if (h_take && !h_cfg.wr && h_cfg.addr == HCFG_PRODUCT_DATA)
      begin
        pd_rd_addr_reg <= pd_rd_addr_next;
      end
    end
  end

  // ****************************************
  // ROM window forwarding
  // ****************************************
  // One access at a time; the host is retried until it returns
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fwd_busy_reg <= 1'b0;
      fwd_addr_reg <= 32'h0000_0000;
    end
    else if (fwd_busy_reg)
    begin
      if (l_fwd_ready)
      begin
        fwd_busy_reg <= 1'b0;
      end
    end
    else if (h_mem_req && !h_mem_retry)
    begin
      fwd_busy_reg <= 1'b1;
      fwd_addr_reg <= {rom_ctrl_reg.translation, h_mem_addr[15:0]}; // RULE_10
    end
  end

  // ****************************************
  // EEPROM write request
  // ****************************************
  // Request holds until the EEPROM channel reports done
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ee_wr_valid <= 1'b0;
      ee_wr <= '0;
    end
    else if (ee_wr_valid)
    begin
      if (ee_wr_done)
      begin
        ee_wr_valid <= 1'b0;
      end
    end
    else if (ee_take_host)
    begin
      ee_wr_valid <= 1'b1; // RULE_09
      // Index becomes the EEPROM address, the byte its data
      ee_wr <= {h_cfg.wdata[7:0], h_cfg.wdata[15:8]};
    end
    else if (ee_take_local)
    begin
      ee_wr_valid <= 1'b1; // RULE_09
      ee_wr <= l_reg.wdata[15:0];
    end
  end
endmodule : pir_rom_window

// ===== pir_pkg.sv
// ****************************************
// Shared constants and carriers
// ****************************************
package pir_pkg;
  // Host configuration offsets (byte addresses)
  localparam logic [7:0] HCFG_CMD_STATUS = 8'h04;
  localparam logic [7:0] HCFG_CLASS = 8'h08;
  localparam logic [7:0] HCFG_MEMBASE_NORMAL = 8'h10;
  localparam logic [7:0] HCFG_MEMBASE_MOVED = 8'h18;
  localparam logic [7:0] HCFG_ROM_BASE = 8'h30;
  localparam logic [7:0] HCFG_PRODUCT_DATA = 8'h40;
  // Local processor offsets
  localparam logic [7:0] LREG_MISC_TWO = 8'h00;
  localparam logic [7:0] LREG_MSG_CTRL = 8'h04;
  localparam logic [7:0] LREG_CLASS = 8'h08;
  localparam logic [7:0] LREG_EE_CTRL = 8'h0c;
  localparam logic [7:0] LREG_ROM_CTRL = 8'h10;
  // Field positions
  localparam int MEM_SPACE_BIT = 1;
  localparam int ROM_EN_BIT = 0;
  localparam int ACCESS_BLOCK_BIT = 0;
  localparam int MSG_EN_BIT = 0;
  localparam int EE_BUSY_BIT = 31;
  // Reset values and the memory base mask
  localparam logic [31:0] CLASS_RESET = 32'h0000_0000;
  localparam logic ACCESS_BLOCK_RESET = 1'b1;
  localparam logic [31:0] ROM_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] MEMBASE_MASK = 32'hffff_f000;
  // Load selectors from the serial EEPROM channel
  localparam logic [1:0] LOAD_CLASS = 2'h0;
  localparam logic [1:0] LOAD_ROM_CTRL = 2'h1;
  localparam logic [1:0] LOAD_ROM_BASE = 2'h2;

  // Read-only ROM window control, loaded from EEPROM
  typedef struct packed {
    logic [15:0] translation;  // rom_translation_field
    logic [3:0] unused_hi;
    logic [3:0] transfer_code; // drives transfer_code_lines
    logic [2:0] unused_mid;
    logic [2:0] block_size;    // rom_block_size
    logic [1:0] width;         // rom_width_field
  } pir_rom_ctrl_t;

  // One EEPROM byte write
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } pir_ee_write_t;

  // Register access request
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } pir_reg_req_t;
endpackage : pir_pkg

// ===== pir_product_mem.sv
`timescale 1ns/1ns
// ****************************************
// Product data shadow memory
// ****************************************
module pir_product_mem
  import pir_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW = 4
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port, data registered
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  // Storage, no reset needed on the array
  logic [7:0] mem_reg [DEPTH];

  // Array write
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // Registered read
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data <= 8'h00;
    end
    else
    begin
      rd_data <= mem_reg[rd_addr];
    end
  end
endmodule : pir_product_mem

// ===== pir_rom_window_properties.sv
`timescale 1ns/1ns
// ****
// Port checks
// ****
module pir_rom_window_properties
  import pir_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host side
  input wire logic h_cfg_req,
  input wire logic h_cfg_ack,
  input wire logic h_cfg_retry,
  input wire logic h_mem_req,
  input wire logic [31:0] h_mem_addr,
  input wire logic h_mem_ack,
  input wire logic h_mem_retry,
  // Local side
  input wire logic l_fwd_valid,
  input wire logic [31:0] l_fwd_addr,
  input wire logic [3:0] transfer_code_lines,
  input wire logic l_fwd_ready,
  input wire logic ee_wr_valid,
  input wire pir_ee_write_t ee_wr,
  input wire logic ee_wr_done
);
  // Last host address, for the forward check
  logic [31:0] prev_addr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Keeps the whole address of the request; the check compares bits 15:0
  always_ff @(posedge clk)
    prev_addr <= h_mem_addr;
  property p_cfg_answer; h_cfg_req |-> (h_cfg_ack ^ h_cfg_retry); endproperty
  a_cfg_answer: assert property (p_cfg_answer) else $error("cfg answer");
  property p_mem_ack; h_mem_ack == (l_fwd_valid && l_fwd_ready); endproperty
  a_mem_ack: assert property (p_mem_ack) else $error("mem ack");
  property p_fwd_hold; l_fwd_valid && !l_fwd_ready |=> l_fwd_valid && $stable(l_fwd_addr); endproperty
  a_fwd_hold: assert property (p_fwd_hold) else $error("fwd hold");
  property p_fwd_drop; l_fwd_valid && l_fwd_ready |=> !l_fwd_valid; endproperty
  a_fwd_drop: assert property (p_fwd_drop) else $error("fwd drop");
  property p_fwd_low; $rose(l_fwd_valid) |-> $past(h_mem_req) && l_fwd_addr[15:0] == prev_addr[15:0]; endproperty
  a_fwd_low: assert property (p_fwd_low) else $error("fwd addr");
  property p_fwd_start; $rose(l_fwd_valid) |-> $past(h_mem_req) && !$past(h_mem_retry); endproperty
  a_fwd_start: assert property (p_fwd_start) else $error("fwd start");
  property p_tc_idle; !l_fwd_valid |-> transfer_code_lines == 4'h0; endproperty
  a_tc_idle: assert property (p_tc_idle) else $error("tc idle");
  property p_tc_steady; l_fwd_valid && $past(l_fwd_valid) |-> $stable(transfer_code_lines); endproperty
  a_tc_steady: assert property (p_tc_steady) else $error("tc steady");
  property p_ee_hold; ee_wr_valid && !ee_wr_done |=> ee_wr_valid && $stable(ee_wr); endproperty
  a_ee_hold: assert property (p_ee_hold) else $error("ee hold");
endmodule : pir_rom_window_properties

bind pir_rom_window pir_rom_window_properties u_props (.clk, .rst, .h_cfg_req, .h_cfg_ack, .h_cfg_retry,
  .h_mem_req, .h_mem_addr, .h_mem_ack, .h_mem_retry, .l_fwd_valid, .l_fwd_addr, .transfer_code_lines, .l_fwd_ready,
  .ee_wr_valid, .ee_wr, .ee_wr_done);

// ===== pir_far_model.sv
`timescale 1ns/1ns
// ****
// Local bus ROM and EEPROM responder
// ****
module pir_far_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Requests seen
  input wire logic l_fwd_valid,
  input wire logic ee_wr_valid,
  input wire logic [3:0] dly,
  // Answers
  output logic l_fwd_ready,
  output logic ee_wr_done
);
  logic [3:0] fcnt; // Wait cycles on the ROM forward
  logic [1:0] ecnt; // Wait cycles on the EEPROM write
  // Slow or prompt answer, set by the bench
  always_ff @(posedge clk or posedge rst)
    if (rst)
      fcnt <= 4'h0;
    else
      fcnt <= (l_fwd_valid && !l_fwd_ready) ? fcnt + 4'h1 : 4'h0;
  assign l_fwd_ready = l_fwd_valid && (fcnt >= dly);
  // Serial write always answers done in its third cycle
  always_ff @(posedge clk or posedge rst)
    if (rst)
      ecnt <= 2'h0;
    else
      ecnt <= (ee_wr_valid && !ee_wr_done) ? ecnt + 2'h1 : 2'h0;
  assign ee_wr_done = ee_wr_valid && (ecnt == 2'h2);
endmodule : pir_far_model

// ===== tb_pir_rom_window.sv
`timescale 1ns/1ns
// ****
// Bench
// ****
module tb_pir_rom_window;
  import pir_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e;} pir_row_t;
  logic clk, rst, h_cfg_req, h_cfg_ack, h_cfg_retry, h_mem_req, h_mem_ack, h_mem_retry;
  logic l_fwd_valid, l_fwd_ready, l_req, l_ack, ee_ld_valid, ee_wr_valid, ee_wr_done, ok;
  logic [31:0] h_cfg_rdata, h_mem_addr, l_fwd_addr, l_rdata, ee_ld_data, q;
  logic [3:0] transfer_code_lines, dly, tc;
  logic [1:0] ee_ld_sel;
  pir_reg_req_t h_cfg, l_reg;
  pir_ee_write_t ee_wr;
  pir_rom_ctrl_t rc;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  // Local register rows: write or read, then read back under a mask
  pir_row_t rows [7] = '{
    '{1'b0, LREG_MISC_TWO, 32'h0, 32'h1, {31'h0, ACCESS_BLOCK_RESET}},
    '{1'b0, LREG_CLASS, 32'h0, 32'hffff_ffff, CLASS_RESET},
    '{1'b0, LREG_ROM_CTRL, 32'h0, 32'hffff_ffff, ROM_CTRL_RESET},
    '{1'b1, LREG_CLASS, 32'h0b40_0012, 32'hffff_ffff, 32'h0b40_0012},
    '{1'b1, LREG_ROM_CTRL, 32'hffff_ffff, 32'hffff_ffff, ROM_CTRL_RESET},
    '{1'b1, LREG_MSG_CTRL, 32'h1, 32'h1, 32'h1},
    '{1'b1, LREG_MSG_CTRL, 32'h0, 32'h1, 32'h0}};
  pir_rom_window uut (.clk(clk), .rst(rst), .h_cfg_req(h_cfg_req), .h_cfg(h_cfg), .h_cfg_ack(h_cfg_ack),
    .h_cfg_retry(h_cfg_retry), .h_cfg_rdata(h_cfg_rdata), .h_mem_req(h_mem_req), .h_mem_addr(h_mem_addr),
    .h_mem_ack(h_mem_ack), .h_mem_retry(h_mem_retry), .l_fwd_valid(l_fwd_valid), .l_fwd_addr(l_fwd_addr),
    .transfer_code_lines(transfer_code_lines), .l_fwd_ready(l_fwd_ready), .l_req(l_req), .l_reg(l_reg),
    .l_ack(l_ack), .l_rdata(l_rdata), .ee_ld_valid(ee_ld_valid), .ee_ld_sel(ee_ld_sel),
    .ee_ld_data(ee_ld_data), .ee_wr_valid(ee_wr_valid), .ee_wr(ee_wr), .ee_wr_done(ee_wr_done));
  pir_far_model u_far (.clk(clk), .rst(rst), .l_fwd_valid(l_fwd_valid), .ee_wr_valid(ee_wr_valid),
    .dly(dly), .l_fwd_ready(l_fwd_ready), .ee_wr_done(ee_wr_done));
  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Verdict and stop
  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // One compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Local access, held until acked; data a cycle later
  task automatic lreg(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int i;
    i = 0;
    @(posedge clk);
    l_req <= 1'b1;
    l_reg <= '{w, a, d};
    do @(posedge clk); while (l_ack !== 1'b1 && ++i < 30);
    chk("l_ack", 32'h1, l_ack);
    l_req <= 1'b0;
    #1 r = l_rdata;
  endtask : lreg
  // Host configuration access, ends on ack or retry
  task automatic hcfg(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int i;
    i = 0;
    @(posedge clk);
    h_cfg_req <= 1'b1;
    h_cfg <= '{w, a, d};
    do @(posedge clk); while (h_cfg_ack !== 1'b1 && h_cfg_retry !== 1'b1 && ++i < 30);
    ok = h_cfg_ack;
    h_cfg_req <= 1'b0;
    #1 r = h_cfg_rdata;
  endtask : hcfg
  // ROM image read; a refused one never sees ack
  task automatic hmem(input logic [31:0] a);
    int i;
    i = 0;
    @(posedge clk);
    h_mem_req <= 1'b1;
    h_mem_addr <= a;
    do @(posedge clk); while (h_mem_ack !== 1'b1 && ++i < 20);
    ok = h_mem_ack;
    q = l_fwd_addr;
    tc = transfer_code_lines;
    if (ok !== 1'b1)
      chk("mem retry", 32'h1, h_mem_retry);
    h_mem_req <= 1'b0;
  endtask : hmem
  // One EEPROM load pulse
  task automatic eeld(input logic [1:0] s, input logic [31:0] d);
    @(posedge clk);
    ee_ld_valid <= 1'b1;
    ee_ld_sel <= s;
    ee_ld_data <= d;
    @(posedge clk);
    ee_ld_valid <= 1'b0;
  endtask : eeld
  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  // Main sequence
  initial
  begin
    {rst, h_cfg_req, h_mem_req, l_req, ee_ld_valid} = 5'h10;
    {h_cfg, l_reg, h_mem_addr, ee_ld_sel, ee_ld_data, dly} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    hcfg(1'b0, HCFG_CLASS, 32'h0, q);
    chk("blocked", 32'h0, ok);
    foreach (rows[k])
    begin
      lreg(rows[k].w, rows[k].a, rows[k].d, q);
      if (rows[k].w)
        lreg(1'b0, rows[k].a, 32'h0, q);
      chk("local reg", rows[k].e, q & rows[k].m);
    end
    eeld(LOAD_CLASS, 32'h0c03_3000);
    lreg(1'b0, LREG_CLASS, 32'h0, q);
    chk("ee class", 32'h0c03_3000, q);
    rc = '{translation: 16'h00a5, transfer_code: 4'h9, block_size: 3'h3, width: 2'h2, default: '0};
    eeld(LOAD_ROM_CTRL, rc);
    lreg(1'b0, LREG_ROM_CTRL, 32'h0, q);
    chk("rom ctrl", rc, q);
    eeld(LOAD_ROM_BASE, 32'h0004_0001);
    lreg(1'b1, LREG_MISC_TWO, 32'h0, q);
    hcfg(1'b0, HCFG_CLASS, 32'h0, q);
    chk("open class", 32'h0c03_3000, q);
    hcfg(1'b0, HCFG_ROM_BASE, 32'h0, q);
    chk("rom base", 32'h0004_0001, q & 32'hffff_0001);
    dly <= 4'h3;
    hmem(32'h0004_1234);
    chk("no mem space", 32'h0, ok);
    hcfg(1'b1, HCFG_CMD_STATUS, 32'h1 << MEM_SPACE_BIT, q);
    hmem(32'h0004_1234);
    chk("slow hit", 32'h1, ok);
    chk("fwd addr", {rc.translation, 16'h1234}, q);
    chk("tc lines", rc.transfer_code, tc);
    dly <= 4'h0;
    hmem(32'h0004_fffc);
    chk("prompt hit", 32'h1, ok);
    chk("prompt addr", {rc.translation, 16'hfffc}, q);
    hmem(32'h0005_0000);
    chk("miss", 32'h0, ok);
    hcfg(1'b1, HCFG_ROM_BASE, 32'h0008_0000, q);
    hmem(32'h0008_0010);
    chk("rom off", 32'h0, ok);
    hcfg(1'b1, HCFG_ROM_BASE, 32'h0008_0001, q);
    hmem(32'h0008_0010);
    chk("new base", 32'h1, ok);
    lreg(1'b1, LREG_MSG_CTRL, 32'h1, q);
    hcfg(1'b1, HCFG_MEMBASE_MOVED, 32'habcd_e123, q);
    hcfg(1'b0, HCFG_MEMBASE_MOVED, 32'h0, q);
    chk("moved base", 32'habcd_e123 & MEMBASE_MASK, q);
    hcfg(1'b0, HCFG_MEMBASE_NORMAL, 32'h0, q);
    chk("old base", 32'h0, q);
    hcfg(1'b1, HCFG_PRODUCT_DATA, 32'h5a03, q);
    chk("pd write", {1'b1, 8'h03, 8'h5a}, {ee_wr_valid, ee_wr});
    hcfg(1'b0, HCFG_PRODUCT_DATA, 32'h0300, q);
    chk("pd read", 32'h0000_5a00, q);
    lreg(1'b1, LREG_EE_CTRL, 32'h07c3, q);
    chk("ee ctrl", {1'b1, 8'h07, 8'hc3}, {ee_wr_valid, ee_wr});
    lreg(1'b0, LREG_EE_CTRL, 32'h0, q);
    chk("ee busy", 32'h8000_07c3, q);
    repeat (4) @(posedge clk);
    // Reset in mid-run brings the access block back
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    hcfg(1'b0, HCFG_CLASS, 32'h0, q);
    chk("reset blocked", 32'h0, ok);
    lreg(1'b0, LREG_CLASS, 32'h0, q);
    chk("reset class", CLASS_RESET, q);
    lreg(1'b0, LREG_EE_CTRL, 32'h0, q);
    chk("reset ee idle", 32'h0, q);
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule : tb_pir_rom_window
